// *** fbl_host.sv ***
/*
 * Host controller for the block lock feature of a NAND flash part.
 * Software writes orders over APB; the sequencer drives the command,
 * address, strobe, write-protect and lock-enable pins and reads back
 * one status byte for the status reads.
 * Assumes a 40 MHz clk, a synchronous reset, and a flash whose
 * ready_busy_n and data pins are pulled to defined levels on the board.
 */
// Our own choices: the register offsets and register access over APB.
// Functional notes
// RL1: Lock enable pin high enables locking, autoread.
// RL2: All blocks locked at power-up, wp pulse.
// RL3: Lock-tight blocks ignore software; wp pulse relocks.
// RL4: Command 2Ah locks the blocks.
// RL5: Lock acts on the whole device.
// RL6: Lock command relocks unlocked blocks.
// RL7: Unlock: 23h, start, 24h, end address.
// RL8: Program and erase only on unlocked blocks.
// RL9: Only one contiguous unlocked range exists.
// RL10: Start address not above end address.
// RL11: Equal start and end unlock one block.
// RL12: Full-range and edge-block unlock boundary cases.
// RL13: Command 2Ch makes blocks lock-tight.
// RL14: Lock-tight changes only locked blocks.
// RL15: Locked program or erase: busy 1-10 us.
// RL16: Status read: 7Ah then block address.
// RL17: Status output stays current without toggling.
// RL18: No lock status read while busy.
// RL19: Lock status read mode persists until new command.
// RL20: Lock pin high uses 7Ah, else 70h.
// RL21: Power-on auto read of first page.
// RL22: Read-out may start right after auto read.
// RL23: Ready/busy low while an operation runs.
// RL24: Refused program or erase leaves array unchanged.
// RL25: Three states per block, checked before writes.
`timescale 1ns/1ps
`default_nettype none
`include "fbl_defines.svh"

module fbl_host (
	input  wire logic        clk,       // 40 MHz system clock.
	input  wire logic        srst,      // Synchronous reset, active high.
	input  wire logic [31:0] paddr,     // APB address.
	input  wire logic        psel,      // APB select.
	input  wire logic        penable,   // APB enable.
	input  wire logic        pwrite,    // APB direction.
	input  wire logic [31:0] pwdata,    // APB write data.
	output logic      [31:0] prdata,    // APB read data, registered.
	output logic             pready,    // APB ready.
	output logic             pslverr,   // APB error, registered.
	output logic             chipEnN,   // Flash chip enable, active low.
	output logic             cmdLatch,  // Flash command latch enable.
	output logic             addrLatch, // Flash address latch enable.
	output logic             writeEnN,  // Flash write strobe, active low.
	output logic             read_enable_n, // Flash read strobe.
	output logic             writeProtN,    // Flash write protect pin.
	output logic             autoreadLockEn, // Lock and autoread enable.
	output logic      [7:0]  ioOut,     // Flash data pins, driven value.
	output logic             ioOe,      // High while driving data pins.
	input  wire logic [7:0]  ioIn,      // Flash data pins, sampled.
	input  wire logic        ready_busy_n // Flash ready/busy pin.
);

	////////////////////////////////////////////////////////////////////
	// Timing counts derived from the pin figures, rounded up.
	localparam logic [3:0] TWP_C  = 4'((`FBL_TWP_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS);
	localparam logic [3:0] TWH_C  = 4'((`FBL_TWH_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS);
	localparam logic [3:0] TWHR_C = 4'((`FBL_TWHR_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS);
	// The read wait adds the synchroniser delay of the data pins.
	localparam logic [3:0] TREA_C = 4'((`FBL_TREA_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS + `FBL_SYNC_CYC);
	localparam logic [3:0] TWW_C  = 4'((`FBL_TWW_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS);
	// Ready/busy may take this long to fall, plus the synchroniser.
	localparam logic [3:0] TWB_C  = 4'((`FBL_TWB_NS + `FBL_CLK_NS - 1)
		/ `FBL_CLK_NS + `FBL_SYNC_CYC);

	////////////////////////////////////////////////////////////////////
	// Pin input synchronisers.
	logic [8:0] pinSync;   // Synchronised {ready_busy_n, ioIn}.
	logic       rbSync;    // Synchronised ready level.
	logic [7:0] ioSync;    // Synchronised data pins.

	fbl_sync #(.W(9)) uSync (
		.clk    (clk),
		.srst   (srst),
		.din    ({ready_busy_n, ioIn}),
		.rstVal (9'h100),
		.dout   (pinSync)
	);
	assign rbSync = pinSync[8];
	assign ioSync = pinSync[7:0];

	////////////////////////////////////////////////////////////////////
	// APB register group.
	logic [1:0]  ctrl, next_ctrl;         // {wp level, lock enable}.
	logic [15:0] startAddr, next_startAddr; // Unlock start block.
	logic [15:0] endAddr, next_endAddr;   // Unlock end / status block.
	logic        errFlag, next_errFlag;   // Sticky refused-order flag.
	logic [31:0] next_prdata;             // Read data for access phase.
	logic        next_pslverr;            // Error for access phase.
	logic        go;                      // One-cycle start of an order.
	logic [2:0]  goOp;                    // Operation that go starts.
	logic        busy;                    // Sequencer not idle.
	logic [7:0]  readData;                // Last status byte read.
	fbl_pkg::fbl_state_e state, next_state; // Sequencer state.

	assign busy   = (state != fbl_pkg::ST_IDLE);
	assign pready = 1'b1;                 // Zero wait states.

	// Decode in the setup phase so prdata and pslverr come from flops
	// and stand through the access phase.
	always_comb begin
		logic setupCyc;
		logic errSet;
		setupCyc       = psel & ~penable;
		errSet         = 1'b0;
		next_ctrl      = ctrl;
		next_startAddr = startAddr;
		next_endAddr   = endAddr;
		next_prdata    = 32'h0;
		next_pslverr   = 1'b0;
		go             = 1'b0;
		goOp           = pwdata[`FBL_CMD_MSB:0];
		if (setupCyc && pwrite && paddr == `FBL_OFF_CTRL) begin
			next_ctrl = pwdata[1:0];
		end else if (setupCyc && pwrite && paddr == `FBL_OFF_CMD) begin
			// Orders while busy, unknown codes and reversed ranges are
			// refused and flagged; the flash never sees them.
			if (busy || goOp > fbl_pkg::OP_STAT) begin
				errSet = 1'b1;
			end else if (goOp == fbl_pkg::OP_UNLOCK &&
				startAddr > endAddr) begin
				errSet = 1'b1;                            // [RL10]
			end else begin
				go = 1'b1;
			end
		end else if (setupCyc && pwrite && paddr == `FBL_OFF_START) begin
			next_startAddr = pwdata[15:0];
		end else if (setupCyc && pwrite && paddr == `FBL_OFF_END) begin
			next_endAddr = pwdata[15:0];
		end else if (setupCyc && paddr == `FBL_OFF_STATUS) begin
			next_prdata[`FBL_ST_BUSY] = busy;
			next_prdata[`FBL_ST_RDY]  = rbSync;
			next_prdata[`FBL_ST_ERR]  = errFlag;
			next_prdata[`FBL_ST_DMSB:`FBL_ST_DLSB] = readData;
		end else if (setupCyc && !pwrite && paddr == `FBL_OFF_CTRL) begin
			next_prdata[1:0] = ctrl;
		end else if (setupCyc && !pwrite && paddr == `FBL_OFF_START) begin
			next_prdata[15:0] = startAddr;
		end else if (setupCyc && !pwrite && paddr == `FBL_OFF_END) begin
			next_prdata[15:0] = endAddr;
		end else if (setupCyc && paddr != `FBL_OFF_CMD) begin
			next_pslverr = 1'b1;                  // Unmapped address.
		end
		// Writing one to the error bit clears it; a new refusal in the
		// same cycle wins.
		next_errFlag = errFlag;
		if (setupCyc && pwrite && paddr == `FBL_OFF_STATUS &&
			pwdata[`FBL_ST_ERR]) begin
			next_errFlag = 1'b0;
		end
		if (errSet) begin
			next_errFlag = 1'b1;
		end
	end

	// Register the APB group.
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl      <= `FBL_CTRL_RST;
			startAddr <= 16'h0000;
			endAddr   <= 16'h0000;
			errFlag   <= 1'b0;
			prdata    <= 32'h0;
			pslverr   <= 1'b0;
		end else begin
			ctrl      <= next_ctrl;
			startAddr <= next_startAddr;
			endAddr   <= next_endAddr;
			errFlag   <= next_errFlag;
			prdata    <= next_prdata;
			pslverr   <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequencer group.
	logic [2:0]  op, next_op;             // Operation in progress.
	logic [2:0]  idx, next_idx;           // Bus cycle index.
	logic [3:0]  timer, next_timer;       // Cycles left in this state.
	logic [15:0] sBlk, next_sBlk;         // Latched start block.
	logic [15:0] eBlk, next_eBlk;         // Latched end block.
	logic [7:0]  next_readData;           // Next status byte.
	logic        next_chipEnN, next_cmdLatch, next_addrLatch;
	logic        next_writeEnN, next_reN, next_writeProtN, next_ioOe;
	logic [7:0]  next_ioOut;
	logic        seqCmd;                  // Current cycle is a command.
	logic        seqLast;                 // Current cycle is the last.
	logic [7:0]  seqByte;                 // Byte of the current cycle.

	// Byte list of each order, low address byte first.
	always_comb begin
		seqCmd  = 1'b1;
		seqLast = 1'b1;
		seqByte = `FBL_CODE_LOCK;                           // [RL4] [RL5]
		case (op)
			fbl_pkg::OP_TIGHT: seqByte = `FBL_CODE_TIGHT;   // [RL13]
			fbl_pkg::OP_STAT:  seqByte = `FBL_CODE_STAT;    // [RL20]
			fbl_pkg::OP_UNLOCK: begin                      // [RL7]
				seqLast = (idx == 3'd5);
				seqCmd  = (idx == 3'd0) || (idx == 3'd3);
				case (idx)
					3'd0: seqByte = `FBL_CODE_UNLK1;
					3'd1: seqByte = sBlk[7:0];
					3'd2: seqByte = sBlk[15:8];
					3'd3: seqByte = `FBL_CODE_UNLK2;
					3'd4: seqByte = eBlk[7:0];
					default: seqByte = eBlk[15:8];
				endcase
			end
			fbl_pkg::OP_LSTAT: begin                       // [RL16]
				seqLast = (idx == 3'd2);
				seqCmd  = (idx == 3'd0);
				case (idx)
					3'd0: seqByte = `FBL_CODE_LSTAT;
					3'd1: seqByte = eBlk[7:0];
					default: seqByte = eBlk[15:8];
				endcase
			end
			default: seqByte = `FBL_CODE_LOCK;
		endcase
	end

	// Next-state logic of the pin sequencer.
	always_comb begin
		next_state      = state;
		next_op         = op;
		next_idx        = idx;
		next_timer      = (timer != 4'h0) ? timer - 4'h1 : 4'h0;
		next_sBlk       = sBlk;
		next_eBlk       = eBlk;
		next_readData   = readData;
		next_chipEnN    = chipEnN;
		next_cmdLatch   = cmdLatch;
		next_addrLatch  = addrLatch;
		next_writeEnN   = writeEnN;
		next_reN        = read_enable_n;
		next_ioOut      = ioOut;
		next_ioOe       = ioOe;
		// The protect pin follows software except during a pulse.
		next_writeProtN = ctrl[`FBL_CTRL_WP];
		case (state)
			fbl_pkg::ST_IDLE: begin
				if (go && goOp == fbl_pkg::OP_WPULSE) begin
					next_state      = fbl_pkg::ST_WPLO;    // [RL2] [RL3]
					next_writeProtN = 1'b0;
					next_timer      = TWW_C - 4'h1;
				end else if (go) begin
					next_state = fbl_pkg::ST_PRE;
					next_op    = goOp;
					next_idx   = 3'd0;
					next_sBlk  = startAddr;                // [RL11] [RL12]
					next_eBlk  = endAddr;
				end
			end
			fbl_pkg::ST_WPLO: begin
				next_writeProtN = 1'b0;
				if (timer == 4'h0) begin
					next_writeProtN = ctrl[`FBL_CTRL_WP];
					next_state      = fbl_pkg::ST_IDLE;
				end
			end
			fbl_pkg::ST_PRE: begin
				// Nothing is sent until the flash reports ready.
				if (rbSync) begin                          // [RL18] [RL23]
					next_state = fbl_pkg::ST_WRLO;
					next_timer = TWP_C - 4'h1;
					next_chipEnN   = 1'b0;
					next_cmdLatch  = seqCmd;
					next_addrLatch = ~seqCmd;
					next_ioOut     = seqByte;
					next_ioOe      = 1'b1;
					next_writeEnN  = 1'b0;
				end
			end
			fbl_pkg::ST_WRLO: begin
				if (timer == 4'h0) begin
					next_writeEnN = 1'b1;              // Flash latches here.
					next_state    = fbl_pkg::ST_WRHI;
					next_timer    = TWH_C - 4'h1;
				end
			end
			fbl_pkg::ST_WRHI: begin
				if (timer != 4'h0) begin
					next_state = fbl_pkg::ST_WRHI;
				end else if (!seqLast) begin
					next_idx   = idx + 3'd1;
					next_state = fbl_pkg::ST_PRE;
				end else if (op == fbl_pkg::OP_LSTAT ||
					op == fbl_pkg::OP_STAT) begin
					next_cmdLatch  = 1'b0;
					next_addrLatch = 1'b0;
					next_ioOe      = 1'b0;
					next_state     = fbl_pkg::ST_WHR;
					next_timer     = TWHR_C - 4'h1;
				end else begin
					next_cmdLatch  = 1'b0;
					next_addrLatch = 1'b0;
					next_ioOe      = 1'b0;
					next_state     = fbl_pkg::ST_WB;
					next_timer     = TWB_C - 4'h1;
				end
			end
			fbl_pkg::ST_WHR: begin
				if (timer == 4'h0) begin
					next_reN   = 1'b0;
					next_state = fbl_pkg::ST_RDLO;
					next_timer = TREA_C - 4'h1;
				end
			end
			fbl_pkg::ST_RDLO: begin
				// The flash keeps the status current, so one sample after
				// the access time is enough.
				if (timer == 4'h0) begin                   // [RL17]
					next_state = fbl_pkg::ST_RDCAP;
				end
			end
			fbl_pkg::ST_RDCAP: begin
				next_readData = ioSync;
				next_reN      = 1'b1;
				next_chipEnN  = 1'b1;
				next_state    = fbl_pkg::ST_IDLE;
			end
			fbl_pkg::ST_WB: begin
				if (timer == 4'h0) begin
					next_state = fbl_pkg::ST_RDY;
				end
			end
			fbl_pkg::ST_RDY: begin
				if (rbSync) begin                          // [RL23]
					next_chipEnN = 1'b1;
					next_state   = fbl_pkg::ST_IDLE;
				end
			end
			default: next_state = fbl_pkg::ST_IDLE;
		endcase
	end

	// Register the sequencer group; the lock enable pin tracks software.
	always_ff @(posedge clk) begin
		if (srst) begin
			state          <= fbl_pkg::ST_IDLE;
			op             <= fbl_pkg::OP_LOCK;
			idx            <= 3'd0;
			timer          <= 4'h0;
			sBlk           <= 16'h0000;
			eBlk           <= 16'h0000;
			readData       <= 8'h00;
			chipEnN        <= 1'b1;
			cmdLatch       <= 1'b0;
			addrLatch      <= 1'b0;
			writeEnN       <= 1'b1;
			read_enable_n  <= 1'b1;
			writeProtN     <= 1'b0;
			ioOut          <= 8'h00;
			ioOe           <= 1'b0;
			autoreadLockEn <= 1'b0;
		end else begin
			state          <= next_state;
			op             <= next_op;
			idx            <= next_idx;
			timer          <= next_timer;
			sBlk           <= next_sBlk;
			eBlk           <= next_eBlk;
			readData       <= next_readData;
			chipEnN        <= next_chipEnN;
			cmdLatch       <= next_cmdLatch;
			addrLatch      <= next_addrLatch;
			writeEnN       <= next_writeEnN;
			read_enable_n  <= next_reN;
			writeProtN     <= next_writeProtN;
			ioOut          <= next_ioOut;
			ioOe           <= next_ioOe;
			autoreadLockEn <= ctrl[`FBL_CTRL_PRE];             // [RL1]
		end
	end

endmodule // fbl_host

`default_nettype wire

// *** fbl_defines.svh ***
/*
 * Constants of the block lock host controller: register offsets, field
 * positions, reset values, flash command codes and pin timing figures.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef FBL_DEFINES_SVH
`define FBL_DEFINES_SVH

// APB register byte offsets, one aligned word each.
`define FBL_OFF_CTRL   32'h0000_0000
`define FBL_OFF_CMD    32'h0000_0004
`define FBL_OFF_START  32'h0000_0008
`define FBL_OFF_END    32'h0000_000c
`define FBL_OFF_STATUS 32'h0000_0010

// Control register fields and reset values.
`define FBL_CTRL_PRE   0
`define FBL_CTRL_WP    1
`define FBL_CTRL_RST   2'h0

// Command register field: operation code in the low bits.
`define FBL_CMD_MSB    2

// Status register fields.
`define FBL_ST_BUSY    0
`define FBL_ST_RDY     1
`define FBL_ST_ERR     2
`define FBL_ST_DLSB    8
`define FBL_ST_DMSB    15

// Flash command codes.
`define FBL_CODE_LOCK   8'h2a
`define FBL_CODE_UNLK1  8'h23
`define FBL_CODE_UNLK2  8'h24
`define FBL_CODE_TIGHT  8'h2c
`define FBL_CODE_LSTAT  8'h7a
`define FBL_CODE_STAT   8'h70

// Pin timing in nanoseconds and the clock period.
`define FBL_CLK_NS   25
`define FBL_TWP_NS   25
`define FBL_TWH_NS   15
`define FBL_TWHR_NS  60
`define FBL_TREA_NS  30
`define FBL_TWW_NS   100
`define FBL_TWB_NS   100

// Cycles spent by the two-flop synchroniser on pin inputs.
`define FBL_SYNC_CYC 2

`endif

// *** fbl_pkg.sv ***
/*
 * Types shared by the block lock host controller.
 * Assumes the defines header is available by bare name.
 */
`include "fbl_defines.svh"

package fbl_pkg;

	// Operations that software orders through the command register.
	typedef enum logic [2:0] {
		OP_LOCK   = 3'b000,
		OP_TIGHT  = 3'b001,
		OP_UNLOCK = 3'b010,
		OP_LSTAT  = 3'b011,
		OP_WPULSE = 3'b100,
		OP_STAT   = 3'b101
	} fbl_op_e;

	// States of the pin sequencer.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_PRE   = 4'b0001,
		ST_WRLO  = 4'b0010,
		ST_WRHI  = 4'b0011,
		ST_WHR   = 4'b0100,
		ST_RDLO  = 4'b0101,
		ST_RDCAP = 4'b0110,
		ST_WPLO  = 4'b0111,
		ST_WB    = 4'b1000,
		ST_RDY   = 4'b1001
	} fbl_state_e;

endpackage

// *** fbl_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk and change slowly enough
 * that each bit is sampled on its own.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_sync #(
	parameter int W = 1               // Number of bits synchronised.
) (
	input  wire logic         clk,    // System clock.
	input  wire logic         srst,   // Synchronous reset, active high.
	input  wire logic [W-1:0] din,    // Asynchronous inputs.
	input  wire logic [W-1:0] rstVal, // Value held during reset.
	output logic      [W-1:0] dout    // Synchronised outputs.
);

	logic [W-1:0] stage1;      // First flop, read only by the second.
	logic [W-1:0] next_stage1; // Next value of the first flop.
	logic [W-1:0] next_dout;   // Next value of the second flop.

	// The reset value is a port only for the clocked load below; it is
	// never loaded asynchronously.
	always_comb begin
		next_stage1 = srst ? rstVal : din;
		next_dout   = srst ? rstVal : stage1;
	end

	// Register both stages.
	always_ff @(posedge clk) begin
		stage1 <= next_stage1;
		dout   <= next_dout;
	end

endmodule // fbl_sync

`default_nettype wire

// *** fbl_host_chk.sv ***
/*
 * Checker for the block lock host controller: pin framing and reset values.
 * Assumes it is bound to fbl_host and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_host_chk (
	input wire logic clk,            // System clock.
	input wire logic srst,           // Synchronous reset, active high.
	input wire logic chipEnN,        // Flash chip enable.
	input wire logic cmdLatch,       // Command latch enable.
	input wire logic addrLatch,      // Address latch enable.
	input wire logic writeEnN,       // Write strobe.
	input wire logic read_enable_n,  // Read strobe.
	input wire logic writeProtN,     // Write protect pin.
	input wire logic autoreadLockEn, // Lock enable pin.
	input wire logic ioOe            // Data pin drive enable.
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// The strobe stays low through the access wait and the sample cycle.
	sequence reLowRun;
		!read_enable_n [*5] ##1 read_enable_n;
	endsequence
	// The protect pulse lasts four cycles, 100 ns.
	sequence wpLowRun;
		!writeProtN [*4] ##1 writeProtN;
	endsequence

	reset_pins_a: assert property (disable iff (1'b0)
		srst |=> chipEnN && writeEnN && read_enable_n && !writeProtN
		&& !ioOe && !autoreadLockEn && !cmdLatch && !addrLatch)
		else $error("pins not at reset levels");
	we_pulse_a: assert property ($fell(writeEnN) |=> writeEnN && !chipEnN)
		else $error("write strobe not one cycle");
	we_frame_a: assert property (!writeEnN |->
		!chipEnN && ioOe && (cmdLatch ^ addrLatch))
		else $error("write strobe outside a byte frame");
	first_cmd_a: assert property ($fell(chipEnN) |->
		!writeEnN && cmdLatch) else $error("order not opened by command");
	re_width_a: assert property ($fell(read_enable_n) |-> reLowRun)
		else $error("read strobe width wrong");
	re_quiet_a: assert property (!read_enable_n |->
		!chipEnN && !ioOe && !cmdLatch && !addrLatch)
		else $error("read strobe with bus driven");
	wp_pulse_a: assert property ($fell(writeProtN) |-> wpLowRun)
		else $error("protect pulse width wrong");
	ce_idle_a: assert property (chipEnN |-> writeEnN && read_enable_n)
		else $error("strobe while chip not enabled");
	lock_pin_a: assert property (!chipEnN |-> $stable(autoreadLockEn))
		else $error("lock enable changed inside an order");
endmodule // fbl_host_chk

bind fbl_host fbl_host_chk u_chk (.*);
`default_nettype wire

// *** fbl_flash_model.sv ***
/*
 * Behavioural flash with block lock: 16 blocks, block = address bits 3:0.
 * Assumes strobes from the host; slow makes orders busy for about 1 us.
 */
`timescale 1ns/1ps
`default_nettype none

module fbl_flash_model #(
	parameter logic [7:0] UNLK_BYTE  = 8'h06, // Status byte, unlocked.
	parameter logic [7:0] LOCK_BYTE  = 8'h02, // Status byte, locked.
	parameter logic [7:0] TIGHT_BYTE = 8'h01  // Status byte, lock-tight.
) (
	input  wire logic       chipEnN,        // Chip enable.
	input  wire logic       cmdLatch,       // Command latch.
	input  wire logic       addrLatch,      // Address latch.
	input  wire logic       writeEnN,       // Write strobe.
	input  wire logic       writeProtN,     // Write protect.
	input  wire logic       autoreadLockEn, // Lock enable pin.
	input  wire logic [7:0] ioOut,          // Host data drive.
	input  wire logic       slow,           // Answer with a busy period.
	output logic      [7:0] ioIn,           // Data seen by the host.
	output logic            ready_busy_n    // Ready, high when idle.
);
	logic [1:0]  blkState [16]; // 0 unlocked, 1 locked, 2 tight.
	logic [7:0]  mode;          // Last command byte.
	logic [15:0] addr;          // Address assembled low byte first.
	logic [15:0] startAddr;     // Start of the unlock range.
	logic [3:0]  lsBlk;         // Block under status read.
	int          nAddr;         // Address bytes since the command.

	// Every block starts locked.
	initial begin
		for (int i = 0; i < 16; i++) blkState[i] = 2'd1;
		mode = 8'h00;
		addr = 16'h0000;
		startAddr = 16'h0000;
		lsBlk = 4'h0;
		nAddr = 0;
		ioIn = 8'h5a;
		ready_busy_n = 1'b1;
	end

	// A protect low pulse relocks all blocks, tight ones too.
	always @(negedge writeProtN) begin
		for (int i = 0; i < 16; i++) blkState[i] = 2'd1;
	end

	// Bytes are latched on the write strobe's rising edge.
	always @(posedge writeEnN) begin
		if (!chipEnN && cmdLatch) begin
			mode = ioOut;
			nAddr = 0;
			// Whole device lock and lock-tight.
			for (int i = 0; i < 16; i++) begin
				if (autoreadLockEn && ioOut == 8'h2a && blkState[i] == 2'd0)
					blkState[i] = 2'd1;
				if (autoreadLockEn && ioOut == 8'h2c && blkState[i] == 2'd1)
					blkState[i] = 2'd2;
			end
			// Busy while the order runs; status reads stay ready.
			if (slow && ioOut != 8'h7a && ioOut != 8'h70) begin
				ready_busy_n <= #5 1'b0;
				ready_busy_n <= #1000 1'b1;
			end
		end else if (!chipEnN && addrLatch) begin
			addr = {ioOut, addr[15:8]};
			nAddr++;
			if (nAddr == 2 && mode == 8'h23) startAddr = addr;
			if (nAddr == 2 && mode == 8'h7a) lsBlk = addr[3:0];
			// One range unlocked, tight blocks untouched.
			if (nAddr == 2 && mode == 8'h24 && autoreadLockEn)
				for (int i = 0; i < 16; i++)
					if (blkState[i] != 2'd2)
						blkState[i] = (i >= startAddr[3:0] && i <= addr[3:0])
							? 2'd0 : 2'd1;
		end
	end

	// Output kept current while enabled; a changing pattern otherwise.
	always #5 begin
		if (!chipEnN && mode == 8'h7a)
			ioIn = (blkState[lsBlk] == 2'd0) ? UNLK_BYTE :
				(blkState[lsBlk] == 2'd1) ? LOCK_BYTE : TIGHT_BYTE;
		else if (!chipEnN && mode == 8'h70)
			ioIn = {writeProtN, 7'h60};
		else
			ioIn = ~ioIn;
	end
endmodule // fbl_flash_model
`default_nettype wire

// *** tb_top.sv ***
/*
 * Self-checking bench: APB orders to the host, behavioural flash behind it.
 * Assumes fbl_host, its package and defines, and the flash model.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fbl_defines.svh"

module tb_top;
	localparam logic [7:0] UB = 8'h06, LB = 8'h02, TB = 8'h01;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, slow = 1'b0, pready, pslverr, chipEnN, cmdLatch;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, s;
	logic addrLatch, writeEnN, read_enable_n, writeProtN, autoreadLockEn;
	logic ioOe, ready_busy_n, e;
	logic [7:0] ioOut, ioIn;
	int fails = 0, compares = 0, cycles = 0;

	always #12.5 clk = ~clk;

	fbl_host DUT (.*);
	fbl_flash_model #(.UNLK_BYTE(UB), .LOCK_BYTE(LB), .TIGHT_BYTE(TB)) flash (.*);

	////////////////////////////////////////////////////////////////////////
	// Closing report, shared by the main sequence and the hang guard.
	task stop_test;
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hung handshake must not stall the run forever.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			stop_test();
		end
	end

	task cmp_word(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task cmp_pin(input string what, input logic exp, got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", what, exp, got);
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// One APB transfer; read data taken at the edge that sees pready.
	task apb(input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
		end
		s = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Polls the busy flag; the bound of 300 polls ends the wait on a wedged order.
	task wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, `FBL_OFF_STATUS, 32'h0);
			n++;
		end while (s[0] !== 1'b0 && n < 300);
		if (s[0] !== 1'b0) fails++;
	endtask

	task order(input logic [31:0] op);
		apb(1'b1, `FBL_OFF_CMD, op);
		wait_idle();
	endtask

	task unlock(input logic [15:0] a, b);
		apb(1'b1, `FBL_OFF_START, {16'h0, a});
		apb(1'b1, `FBL_OFF_END, {16'h0, b});
		order(32'h2);
	endtask

	// Lock status read of one block; byte lands in STATUS[15:8].
	task lstat(input logic [15:0] blk, input logic [7:0] exp);
		apb(1'b1, `FBL_OFF_END, {16'h0, blk});
		order(32'h3);
		cmp_word("lock status", {24'h0, exp}, {24'h0, s[15:8]});
	endtask

	////////////////////////////////////////////////////////////////////////
	task t_reset;
		cmp_pin("protect pin", 1'b0, writeProtN);
		cmp_pin("lock pin", 1'b0, autoreadLockEn);
		apb(1'b0, `FBL_OFF_CTRL, 32'h0);
		cmp_word("ctrl", 32'h0, s);
		apb(1'b0, 32'h20, 32'h0);
		cmp_pin("unmapped err", 1'b1, e);
		apb(1'b1, `FBL_OFF_CTRL, 32'h3);
		@(posedge clk);
		#1 cmp_pin("lock pin on", 1'b1, autoreadLockEn);
		cmp_pin("protect idle", 1'b1, writeProtN);
		lstat(16'h0005, LB);
		$display("test reset done");
	endtask

	task t_unlock;
		unlock(16'h0003, 16'h0007);
		lstat(16'h0003, UB);
		lstat(16'h0007, UB);
		lstat(16'h0008, LB);
		unlock(16'h0009, 16'h0009);
		lstat(16'h0009, UB);
		lstat(16'h0005, LB);
		unlock(16'h0000, 16'hffff);
		lstat(16'h000f, UB);
		lstat(16'h0000, UB);
		unlock(16'hffff, 16'hffff);
		lstat(16'h000f, UB);
		lstat(16'h000e, LB);
		unlock(16'h0000, 16'h0000);
		lstat(16'h0000, UB);
		lstat(16'h0001, LB);
		$display("test unlock done");
	endtask

	task t_lock;
		unlock(16'h0000, 16'hffff);
		order(32'h0);
		lstat(16'h0000, LB);
		lstat(16'h000f, LB);
		unlock(16'h0004, 16'h0006);
		order(32'h1);
		lstat(16'h0004, UB);
		lstat(16'h0002, TB);
		unlock(16'h0000, 16'hffff);
		lstat(16'h0002, TB);
		order(32'h0);
		lstat(16'h0004, LB);
		order(32'h4);
		lstat(16'h0002, LB);
		$display("test lock done");
	endtask

	task t_refuse;
		apb(1'b1, `FBL_OFF_START, 32'h8);
		apb(1'b1, `FBL_OFF_END, 32'h3);
		order(32'h2);
		cmp_word("reversed range err", 32'h4, s & 32'h4);
		apb(1'b1, `FBL_OFF_STATUS, 32'h4);
		order(32'h6);
		cmp_word("bad op err", 32'h4, s & 32'h4);
		apb(1'b1, `FBL_OFF_STATUS, 32'h4);
		slow = 1'b1;
		apb(1'b1, `FBL_OFF_CMD, 32'h0);
		apb(1'b1, `FBL_OFF_CMD, 32'h0);
		apb(1'b0, `FBL_OFF_STATUS, 32'h0);
		cmp_word("busy and err", 32'h5, s & 32'h5);
		wait_idle();
		slow = 1'b0;
		apb(1'b1, `FBL_OFF_STATUS, 32'h4);
		apb(1'b0, `FBL_OFF_STATUS, 32'h0);
		cmp_word("err cleared", 32'h0, s & 32'h4);
		$display("test refuse done");
	endtask

	task t_plain;
		apb(1'b1, `FBL_OFF_CTRL, 32'h2);
		@(posedge clk);
		#1 cmp_pin("lock pin off", 1'b0, autoreadLockEn);
		order(32'h5);
		cmp_word("status byte", {24'h0, 1'b1, 7'h60}, {24'h0, s[15:8]});
		$display("test plain done");
	endtask

	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1 t_reset();
		t_unlock();
		t_lock();
		t_refuse();
		t_plain();
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
